// >>> lcr_row_scan_driver.sv
// Row scan driver of a common LCD driver with a Wishbone register slave.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - Provide all row outputs; split select high gives two half chains, low one chain.
// - Direction low scans upward, first pin in; high scans downward, pins swap.
// - Scan register moves only at the falling edge of the row shift clock.
// - The output data pin changes only at that falling edge, carrying the pulse on.
// - In split mode the second chain takes its pulse from the second chain input.
// - Blanking low forces every row to the bottom bias level.
// - The polarity input selects the drive polarity of the rows.
// - Stop detector output is its result ANDed with the gate input.
// - A spare two-input NAND gate drives its own output.
// - Drivers cascade through the data pins with no per-driver enable.
// - Selected row: top when polarity low, bottom when high; else fourth or second.
// - Detector output falls when the clock stops; it may feed blanking.
module lcr_row_scan_driver #(
    parameter int unsigned ROWS = lcr_pkg::ROW_COUNT,
    parameter int unsigned STOP_TIMEOUT = lcr_pkg::STOP_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lcr_pkg::BUS_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rowShiftClock,
    input wire logic scanDirectionSelect,
    input wire logic chainSplitSelect,
    input wire logic scanIoFirstIn,
    output logic scanIoFirstOut,
    output logic scanIoFirstOeN,
    input wire logic scanIoSecondIn,
    output logic scanIoSecondOut,
    output logic scanIoSecondOeN,
    input wire logic scanInSecondChain,
    input wire logic acPolarity,
    input wire logic blankN,
    input wire logic stopDetectClockIn,
    input wire logic stopDetectGateIn,
    output logic stopDetectOut,
    input wire logic spareNandInA,
    input wire logic spareNandInB,
    output logic spareNandOut,
    output logic [2*ROWS-1:0] rowOutputs
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam int unsigned HALF = ROWS / 2;
    localparam int unsigned SCAN_WORDS = ROWS / 32;

    if ((ROWS % 32) != 0 || ROWS < 32 || SCAN_WORDS > 60) begin : g_bad_rows
        $error("Row count must be a multiple of 32 between 32 and 1920.");
    end

    // ------------------------------------------------------------------
    // Shift clock edge
    // ------------------------------------------------------------------
    logic shiftClkPrev_reg;
    wire shiftFall = shiftClkPrev_reg & ~rowShiftClock;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shiftClkPrev_reg <= 1'b0;
        end else begin
            shiftClkPrev_reg <= rowShiftClock;
        end
    end

    // ------------------------------------------------------------------
    // Scan shift register
    // ------------------------------------------------------------------
    logic [ROWS-1:0] scan_reg;
    logic [ROWS-1:0] scan_next;
    wire [ROWS-1:0] fwdIn;
    wire [ROWS-1:0] revIn;
    wire dirDown = scanDirectionSelect;
    wire headIn = dirDown ? scanIoSecondIn : scanIoFirstIn;

    genvar gi;
    for (gi = 0; gi < ROWS; gi++) begin : g_stage
        if (gi == 0) begin : g_fwd_head
            assign fwdIn[gi] = headIn;
        end else if (gi == HALF) begin : g_fwd_split
            assign fwdIn[gi] = chainSplitSelect ? scanInSecondChain : scan_reg[gi-1];
        end else begin : g_fwd_link
            assign fwdIn[gi] = scan_reg[gi-1];
        end
        if (gi == ROWS - 1) begin : g_rev_head
            assign revIn[gi] = headIn;
        end else if (gi == HALF - 1) begin : g_rev_split
            assign revIn[gi] = chainSplitSelect ? scanInSecondChain : scan_reg[gi+1];
        end else begin : g_rev_link
            assign revIn[gi] = scan_reg[gi+1];
        end
    end

    assign scan_next = shiftFall ? (dirDown ? revIn : fwdIn) : scan_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_reg <= '0;
        end else begin
            scan_reg <= scan_next;
        end
    end

    // ------------------------------------------------------------------
    // Cascade data pins
    // ------------------------------------------------------------------
    wire tailOut = dirDown ? scan_next[0] : scan_next[ROWS-1];
    logic firstOut_next;
    logic secondOut_next;

    assign firstOut_next = (shiftFall && dirDown) ? tailOut : scanIoFirstOut;
    assign secondOut_next = (shiftFall && !dirDown) ? tailOut : scanIoSecondOut;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scanIoFirstOut <= 1'b0;
            scanIoSecondOut <= 1'b0;
            scanIoFirstOeN <= 1'b1;
            scanIoSecondOeN <= 1'b1;
        end else begin
            scanIoFirstOut <= firstOut_next;
            scanIoSecondOut <= secondOut_next;
            scanIoFirstOeN <= ~dirDown;
            scanIoSecondOeN <= dirDown;
        end
    end

    // ------------------------------------------------------------------
    // Row levels
    // ------------------------------------------------------------------
    logic softBlank_reg;
    wire blanked = ~blankN | softBlank_reg;

    for (gi = 0; gi < ROWS; gi++) begin : g_row
        lcr_row_level u_level (
            .clk(clk),
            .rst(rst),
            .selected(scan_reg[gi]),
            .polarity(acPolarity),
            .blanked(blanked),
            .level(rowOutputs[2*gi +: 2])
        );
    end

    // ------------------------------------------------------------------
    // Clock stop detector and spare gate
    // ------------------------------------------------------------------
    logic stopped;

    lcr_stop_detector #(
        .TIMEOUT(STOP_TIMEOUT)
    ) u_stop (
        .clk(clk),
        .rst(rst),
        .clockIn(stopDetectClockIn),
        .gateIn(stopDetectGateIn),
        .stopped(stopped),
        .detectOut(stopDetectOut)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spareNandOut <= 1'b1;
        end else begin
            spareNandOut <= ~(spareNandInA & spareNandInB);
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    wire [5:0] regIdx = wb_adr_i[7:2];
    wire [5:0] scanIdx = regIdx - lcr_pkg::IDX_SCAN_BASE;
    wire hitCtrl = (regIdx == lcr_pkg::IDX_CTRL);
    wire hitStatus = (regIdx == lcr_pkg::IDX_STATUS);
    wire hitScan = (regIdx >= lcr_pkg::IDX_SCAN_BASE) && (scanIdx < 6'(SCAN_WORDS));
    wire ackNext = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctrlWrite = ackNext & wb_we_i & hitCtrl & wb_sel_i[0];
    wire [31:0] scanWord = hitScan ? scan_reg[32*scanIdx +: 32] : 32'h0;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [31:0] readData;
    logic softBlank_next;

    always_comb begin
        ctrlWord = 32'h0;
        ctrlWord[lcr_pkg::CTRL_SOFT_BLANK_BIT] = softBlank_reg;
        statusWord = 32'h0;
        statusWord[lcr_pkg::STAT_DIR_BIT] = dirDown;
        statusWord[lcr_pkg::STAT_SPLIT_BIT] = chainSplitSelect;
        statusWord[lcr_pkg::STAT_POL_BIT] = acPolarity;
        statusWord[lcr_pkg::STAT_BLANK_BIT] = blanked;
        statusWord[lcr_pkg::STAT_STOP_BIT] = stopped;
    end

    assign readData = hitCtrl ? ctrlWord : (hitStatus ? statusWord : scanWord);
    assign softBlank_next = ctrlWrite ? wb_dat_i[lcr_pkg::CTRL_SOFT_BLANK_BIT] : softBlank_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            softBlank_reg <= lcr_pkg::CTRL_RESET[lcr_pkg::CTRL_SOFT_BLANK_BIT];
        end else begin
            wb_ack_o <= ackNext;
            wb_dat_o <= ackNext ? readData : wb_dat_o;
            softBlank_reg <= softBlank_next;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_no_shift;
        @(posedge clk) disable iff (rst) !shiftFall |=> $stable(scan_reg);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("Scan register moved without a falling edge.");

    property p_head_up;
        @(posedge clk) disable iff (rst) (shiftFall && !dirDown) |=> scan_reg[0] == $past(scanIoFirstIn);
    endproperty
    a_head_up: assert property (p_head_up) else $error("Upward scan did not load the first pin.");

    property p_head_down;
        @(posedge clk) disable iff (rst) (shiftFall && dirDown) |=> scan_reg[ROWS-1] == $past(scanIoSecondIn);
    endproperty
    a_head_down: assert property (p_head_down) else $error("Downward scan did not load the second pin.");

    property p_split_in;
        @(posedge clk) disable iff (rst)
            (shiftFall && chainSplitSelect && !dirDown) |=> scan_reg[HALF] == $past(scanInSecondChain);
    endproperty
    a_split_in: assert property (p_split_in) else $error("Second chain did not take its own input.");

    property p_single_link;
        @(posedge clk) disable iff (rst)
            (shiftFall && !chainSplitSelect && !dirDown) |=> scan_reg[HALF] == $past(scan_reg[HALF-1]);
    endproperty
    a_single_link: assert property (p_single_link) else $error("Single chain broken at the midpoint.");

    property p_pin_edge;
        @(posedge clk) disable iff (rst)
            ($changed(scanIoFirstOut) || $changed(scanIoSecondOut)) |-> $past(shiftFall);
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("Data pin changed away from a falling edge.");

    property p_cascade;
        @(posedge clk) disable iff (rst) (shiftFall && !dirDown) |=> scanIoSecondOut == scan_reg[ROWS-1];
    endproperty
    a_cascade: assert property (p_cascade) else $error("Cascade pin does not carry the last stage.");

    property p_pin_roles;
        @(posedge clk) disable iff (rst) dirDown |=> (!scanIoFirstOeN && scanIoSecondOeN);
    endproperty
    a_pin_roles: assert property (p_pin_roles) else $error("Pin enables wrong for downward scan.");

    property p_blank;
        @(posedge clk) disable iff (rst) !blankN |=> rowOutputs == {ROWS{lcr_pkg::LVL_BOTTOM}};
    endproperty
    a_blank: assert property (p_blank) else $error("Rows not at bottom level while blanked.");

    property p_row_level;
        @(posedge clk) disable iff (rst)
            1'b1 |=> rowOutputs[1:0] == lcr_pkg::row_level($past(blanked), $past(scan_reg[0]), $past(acPolarity));
    endproperty
    a_row_level: assert property (p_row_level) else $error("Row zero level disagrees with its inputs.");

    property p_polarity;
        @(posedge clk) disable iff (rst)
            (!blanked && scan_reg[0] && !acPolarity) |=> rowOutputs[1:0] == lcr_pkg::LVL_TOP;
    endproperty
    a_polarity: assert property (p_polarity) else $error("Selected row not at top for low polarity.");

    property p_nand;
        @(posedge clk) disable iff (rst) (spareNandInA && spareNandInB) |=> !spareNandOut;
    endproperty
    a_nand: assert property (p_nand) else $error("Spare gate output high with both inputs high.");

    property p_ack_pulse;
        @(posedge clk) disable iff (rst) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Bus acknowledge held longer than one cycle.");

    property p_ack_answer;
        @(posedge clk) disable iff (rst)
            (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("Bus request not acknowledged in the next cycle.");

    property p_split_in_down;
        @(posedge clk) disable iff (rst)
            (shiftFall && chainSplitSelect && dirDown) |=> scan_reg[HALF-1] == $past(scanInSecondChain);
    endproperty
    a_split_in_down: assert property (p_split_in_down) else $error("Second chain missed its input going down.");

    property p_single_link_down;
        @(posedge clk) disable iff (rst)
            (shiftFall && !chainSplitSelect && dirDown) |=> scan_reg[HALF-1] == $past(scan_reg[HALF]);
    endproperty
    a_single_link_down: assert property (p_single_link_down) else $error("Single chain broken going down.");

    property p_cascade_down;
        @(posedge clk) disable iff (rst)
            (shiftFall && dirDown) |=> scanIoFirstOut == scan_reg[0];
    endproperty
    a_cascade_down: assert property (p_cascade_down) else $error("First pin does not carry the last stage.");

    property p_pin_roles_up;
        @(posedge clk) disable iff (rst)
            !dirDown |=> (scanIoFirstOeN && !scanIoSecondOeN);
    endproperty
    a_pin_roles_up: assert property (p_pin_roles_up) else $error("Pin enables wrong for upward scan.");

    property p_unselected_high;
        @(posedge clk) disable iff (rst)
            (!blanked && !scan_reg[0] && acPolarity) |=> rowOutputs[1:0] == lcr_pkg::LVL_SECOND;
    endproperty
    a_unselected_high: assert property (p_unselected_high) else $error("Idle row not at second level.");

    property p_last_row;
        @(posedge clk) disable iff (rst)
            (!blanked && scan_reg[ROWS-1] && !acPolarity) |=> rowOutputs[2*ROWS-1 -: 2] == lcr_pkg::LVL_TOP;
    endproperty
    a_last_row: assert property (p_last_row) else $error("Last row not at top level when selected.");

    property p_nand_high;
        @(posedge clk) disable iff (rst)
            !(spareNandInA && spareNandInB) |=> spareNandOut;
    endproperty
    a_nand_high: assert property (p_nand_high) else $error("Spare gate output low with an input low.");

endmodule // lcr_row_scan_driver

// >>> lcr_pkg.sv
// Package with the constants, level codes and decode function of the common row scan driver.
package lcr_pkg;

    // ------------------------------------------------------------------
    // Geometry and timing
    // ------------------------------------------------------------------
    localparam int unsigned ROW_COUNT = 160;
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
    localparam int unsigned STOP_TIMEOUT_US = 100;
    localparam int unsigned STOP_TIMEOUT_CYCLES = STOP_TIMEOUT_US * CLK_PER_US;

    // ------------------------------------------------------------------
    // Row drive level codes
    // ------------------------------------------------------------------
    localparam logic [1:0] LVL_TOP = 2'h0;
    localparam logic [1:0] LVL_SECOND = 2'h1;
    localparam logic [1:0] LVL_FOURTH = 2'h3;
    localparam logic [1:0] LVL_BOTTOM = 2'h2;

    // ------------------------------------------------------------------
    // Register map, word indices taken from bus byte address bits 7:2
    // ------------------------------------------------------------------
    localparam int unsigned BUS_ADDR_W = 8;
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_SCAN_BASE = 6'h02;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int unsigned CTRL_SOFT_BLANK_BIT = 0;
    localparam int unsigned STAT_DIR_BIT = 0;
    localparam int unsigned STAT_SPLIT_BIT = 1;
    localparam int unsigned STAT_POL_BIT = 2;
    localparam int unsigned STAT_BLANK_BIT = 3;
    localparam int unsigned STAT_STOP_BIT = 4;

    // ------------------------------------------------------------------
    // Level decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] row_level(input logic blanked, input logic selected, input logic polarity);
        logic [1:0] lvl;
        lvl = LVL_BOTTOM;
        if (blanked) begin
            lvl = LVL_BOTTOM;
        end else if (selected) begin
            lvl = polarity ? LVL_BOTTOM : LVL_TOP;
        end else begin
            lvl = polarity ? LVL_SECOND : LVL_FOURTH;
        end
        return lvl;
    endfunction

endpackage

// >>> lcr_row_level.sv
// Registered drive level of one row output.
`timescale 1ns/1ps
module lcr_row_level (
    input wire logic clk,
    input wire logic rst,
    input wire logic selected,
    input wire logic polarity,
    input wire logic blanked,
    output logic [1:0] level
);

    logic [1:0] level_next;

    assign level_next = lcr_pkg::row_level(blanked, selected, polarity);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= lcr_pkg::LVL_BOTTOM;
        end else begin
            level <= level_next;
        end
    end

endmodule // lcr_row_level

// >>> lcr_stop_detector.sv
// Clock stop detector with gated output.
`timescale 1ns/1ps
module lcr_stop_detector #(
    parameter int unsigned TIMEOUT = lcr_pkg::STOP_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clockIn,
    input wire logic gateIn,
    output logic stopped,
    output logic detectOut
);

    localparam int unsigned CW = $clog2(TIMEOUT + 1);
    localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);
    localparam logic [CW-1:0] LIMIT_M1 = CW'(TIMEOUT - 1);

    if (TIMEOUT < 2) begin : g_bad_timeout
        $error("Stop detector timeout must be at least two cycles.");
    end

    logic clkPrev_reg;
    logic [CW-1:0] idle_reg;
    logic [CW-1:0] idle_next;
    logic stoppedNext;
    logic outNext;
    wire clockEdge = clockIn ^ clkPrev_reg;

    assign idle_next = clockEdge ? '0 : ((idle_reg == LIMIT) ? idle_reg : idle_reg + 1'b1);
    assign stoppedNext = (idle_next == LIMIT);
    assign outNext = ~stoppedNext & gateIn;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkPrev_reg <= 1'b0;
            idle_reg <= '0;
            stopped <= 1'b0;
            detectOut <= 1'b0;
        end else begin
            clkPrev_reg <= clockIn;
            idle_reg <= idle_next;
            stopped <= stoppedNext;
            detectOut <= outNext;
        end
    end

    property p_gate_low;
        @(posedge clk) disable iff (rst) !gateIn |=> !detectOut;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("Detector output high with gate low.");

    property p_timeout;
        @(posedge clk) disable iff (rst) $rose(stopped) |-> $past(idle_reg) == LIMIT_M1;
    endproperty
    a_timeout: assert property (p_timeout) else $error("Stop declared at wrong idle count.");

    property p_stop_low;
        @(posedge clk) disable iff (rst) stopped |-> !detectOut;
    endproperty
    a_stop_low: assert property (p_stop_low) else $error("Detector output high while clock stopped.");

    property p_restart;
        @(posedge clk) disable iff (rst) clockEdge |=> !stopped;
    endproperty
    a_restart: assert property (p_restart) else $error("Stop flag held after a clock edge.");

endmodule // lcr_stop_detector

// >>> lcr_ctrl_model.sv
// Behavioural model of the LCD timing controller that feeds the scan inputs.
`timescale 1ns/1ps
module lcr_ctrl_model (
    input wire logic clk,
    input wire logic splitMode,
    output logic rowShiftClock,
    output logic head,
    output logic second
);
    // ----
    // Idle state
    // ----
    initial begin
        rowShiftClock = 1'h0;
        head = 1'h0;
        second = 1'h0;
    end

    // ----
    // One scan step
    // ----
    // Data is set up, the clock falls, and data holds past that edge.
    task automatic step(input logic h, input logic s);
        @(posedge clk);
        rowShiftClock <= 1'h1;
        head <= h;
        second <= splitMode ? s : 1'h0;
        repeat (2) @(posedge clk);
        rowShiftClock <= 1'h0;
        repeat (2) @(posedge clk);
        head <= ~h;
        second <= splitMode ? ~s : 1'h0;
    endtask
endmodule // lcr_ctrl_model

// >>> tb_lcr_row_scan_driver.sv
// Self-checking testbench of the common row scan driver.
`timescale 1ns/1ps
module tb_lcr_row_scan_driver;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, head;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic rowShiftClock, scanDirectionSelect, chainSplitSelect, scanIoFirstIn, scanIoFirstOut, scanIoFirstOeN;
    logic scanIoSecondIn, scanIoSecondOut, scanIoSecondOeN, scanInSecondChain, acPolarity, blankN;
    logic stopDetectClockIn, stopDetectGateIn, stopDetectOut, spareNandInA, spareNandInB, spareNandOut;
    logic [319:0] rowOutputs;
    int numErrors = 0;
    int testsRun = 0;

    // ----
    // Clock, partner and device
    // ----
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    assign scanIoFirstIn = scanIoFirstOeN ? head : scanIoFirstOut;
    assign scanIoSecondIn = scanIoSecondOeN ? head : scanIoSecondOut;
    lcr_ctrl_model ctrl (.clk, .splitMode(chainSplitSelect), .rowShiftClock, .head, .second(scanInSecondChain));
    lcr_row_scan_driver #(.STOP_TIMEOUT(8)) dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .rowShiftClock, .scanDirectionSelect, .chainSplitSelect,
        .scanIoFirstIn, .scanIoFirstOut, .scanIoFirstOeN, .scanIoSecondIn, .scanIoSecondOut, .scanIoSecondOeN,
        .scanInSecondChain, .acPolarity, .blankN, .stopDetectClockIn, .stopDetectGateIn, .stopDetectOut,
        .spareNandInA, .spareNandInB, .spareNandOut, .rowOutputs);

    // ----
    // Shared tasks
    // ----
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chkRows(input int a, input int b, input logic pol, input logic blk);
        logic [1:0] e;
        int bad;
        bad = 0;
        @(negedge clk);
        for (int i = 0; i < 160; i++) begin
            if (blk) e = lcr_pkg::LVL_BOTTOM;
            else if (i == a || i == b) e = pol ? lcr_pkg::LVL_BOTTOM : lcr_pkg::LVL_TOP;
            else e = pol ? lcr_pkg::LVL_SECOND : lcr_pkg::LVL_FOURTH;
            if (rowOutputs[2*i +: 2] !== e) bad++;
        end
        chk("rows", 32'h0, 32'(bad));
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 40);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        if (n >= 40) chk("ack", 32'h1, 32'h0);
    endtask

    task automatic doReset(input logic d, input logic s, input logic p);
        @(posedge clk);
        rst <= 1'h1;
        scanDirectionSelect <= d;
        chainSplitSelect <= s;
        acPolarity <= p;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic tScanUp();
        doReset(1'h0, 1'h0, 1'h0);
        ctrl.step(1'h1, 1'h0);
        chkRows(0, -1, 1'h0, 1'h0);
        repeat (159) ctrl.step(1'h0, 1'h0);
        chkRows(159, -1, 1'h0, 1'h0);
        chk("pins_up", 32'h5, {29'h0, scanIoFirstOeN, scanIoSecondOeN, scanIoSecondOut});
        repeat (4) @(negedge clk);
        chk("held", 32'h1, {31'h0, scanIoSecondOut});
        ctrl.step(1'h0, 1'h0);
        chkRows(-1, -1, 1'h0, 1'h0);
        chk("out_low", 32'h0, {31'h0, scanIoSecondOut});
    endtask

    task automatic tScanDown();
        doReset(1'h1, 1'h0, 1'h1);
        ctrl.step(1'h1, 1'h0);
        chkRows(159, -1, 1'h1, 1'h0);
        repeat (159) ctrl.step(1'h0, 1'h0);
        chkRows(0, -1, 1'h1, 1'h0);
        chk("pins_dn", 32'h3, {29'h0, scanIoFirstOeN, scanIoSecondOeN, scanIoFirstOut});
    endtask

    task automatic tSplit();
        doReset(1'h0, 1'h1, 1'h0);
        wb(1'h0, 8'h00, 32'h0);
        chk("ctrl_rst", 32'h0, rd);
        ctrl.step(1'h1, 1'h1);
        chkRows(0, 80, 1'h0, 1'h0);
        wb(1'h0, 8'h08, 32'h0);
        chk("scan0", 32'h1, rd);
        wb(1'h0, 8'h10, 32'h0);
        chk("scan2", 32'h0001_0000, rd);
        wb(1'h0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        repeat (79) ctrl.step(1'h0, 1'h0);
        chkRows(79, 159, 1'h0, 1'h0);
        chk("split_out", 32'h1, {31'h0, scanIoSecondOut});
        @(posedge clk);
        blankN <= 1'h0;
        @(posedge clk);
        chkRows(-1, -1, 1'h0, 1'h1);
        @(posedge clk);
        blankN <= 1'h1;
        wb(1'h1, 8'h00, 32'h1);
        wb(1'h1, 8'h04, 32'hff);
        wb(1'h0, 8'h04, 32'h0);
        chk("status", 32'ha, rd & 32'hf);
        chkRows(-1, -1, 1'h0, 1'h1);
        wb(1'h1, 8'h00, 32'h0);
        chkRows(79, 159, 1'h0, 1'h0);
    endtask

    task automatic tSplitDown();
        doReset(1'h1, 1'h1, 1'h1);
        ctrl.step(1'h1, 1'h1);
        chkRows(159, 79, 1'h1, 1'h0);
        repeat (79) ctrl.step(1'h0, 1'h0);
        chkRows(80, 0, 1'h1, 1'h0);
        chk("split_dn", 32'h1, {31'h0, scanIoFirstOut});
    endtask

    task automatic tStop();
        @(posedge clk);
        stopDetectGateIn <= 1'h1;
        repeat (12) begin
            repeat (2) @(posedge clk);
            stopDetectClockIn <= ~stopDetectClockIn;
        end
        @(negedge clk);
        chk("stop_run", 32'h1, {31'h0, stopDetectOut});
        repeat (12) @(negedge clk);
        chk("stop_idle", 32'h0, {31'h0, stopDetectOut});
        wb(1'h0, 8'h04, 32'h0);
        chk("stat_stop", 32'h10, rd & 32'h10);
        @(posedge clk);
        stopDetectClockIn <= ~stopDetectClockIn;
        repeat (4) @(negedge clk);
        chk("stop_back", 32'h1, {31'h0, stopDetectOut});
        @(posedge clk);
        stopDetectGateIn <= 1'h0;
        repeat (3) @(negedge clk);
        chk("gate_low", 32'h0, {31'h0, stopDetectOut});
    endtask

    task automatic tNand();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            spareNandInA <= i[0];
            spareNandInB <= i[1];
            repeat (2) @(negedge clk);
            chk("nand", {31'h0, ~(i[0] & i[1])}, {31'h0, spareNandOut});
        end
    endtask

    // ----
    // Main sequence and watchdog
    // ----
    initial begin
        rst = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        scanDirectionSelect = 1'h0;
        chainSplitSelect = 1'h0;
        acPolarity = 1'h0;
        blankN = 1'h1;
        stopDetectClockIn = 1'h0;
        stopDetectGateIn = 1'h0;
        spareNandInA = 1'h0;
        spareNandInB = 1'h0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        tNand();
        tScanUp();
        tScanDown();
        tSplit();
        tSplitDown();
        tStop();
        conclude();
    end

    initial begin
        #500000;
        numErrors++;
        conclude();
    end
endmodule // tb_lcr_row_scan_driver
